// ==== core/lsp_defines.vh ====
`ifndef LSP_DEFINES_VH
`define LSP_DEFINES_VH

// ************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ************************************************************
`define LSP_ADDR_W          8
`define LSP_OFS_CFG         8'h00
`define LSP_OFS_DATA        8'h04
`define LSP_OFS_STATUS      8'h08

// ************************************************************
// Configuration register fields
// ************************************************************
`define LSP_CFG_DIR_LSB     0
`define LSP_CFG_OD_LSB      4
`define LSP_CFG_LED_LSB     8
`define LSP_CFG_RESET       11'h000

// ************************************************************
// Data register fields
// ************************************************************
`define LSP_DATA_OUT_LSB    0
`define LSP_DATA_IN_LSB     4
`define LSP_DATA_RESET      3'h0

// ************************************************************
// Status register fields
// ************************************************************
`define LSP_ST_XOVER        0
`define LSP_ST_LINK         1
`define LSP_ST_SPEED100     2
`define LSP_ST_FULLDUP      3
`define LSP_ST_ANEG         4
`define LSP_ST_BLINK_OFF    5
`define LSP_ST_BLINK_MINON  6

// ************************************************************
// Pin positions of the three shared pins
// ************************************************************
`define LSP_PIN_SPEED       0
`define LSP_PIN_LINKACT     1
`define LSP_PIN_DUPLEX      2

// ************************************************************
// Timing
// ************************************************************
`define LSP_MCLK_KHZ        200000
`define LSP_BLINK_MS        80
`define LSP_BLINK_CYCLES    (`LSP_BLINK_MS * `LSP_MCLK_KHZ)
`define LSP_STRAP_SETTLE    2'h3
`define LSP_XOVER_RESET     1'b1

`endif

// ==== core/lsp_sync2.v ====
`timescale 1ns/1ps

// ************************************************************
// Two-stage synchroniser for pin levels
// ************************************************************
module lsp_sync2
#(
   parameter WIDTH = 1
)
(
   input  wire             mclk,
   input  wire             resetn,
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1;

   // First stage feeds only the second stage
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1  <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end
      else
      begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule

// ==== core/lsp_status_pins.v ====
// What this block does
// - Crossover strap high or floating enables auto crossover; low disables it.
// - Software sets each shared pin as input, push-pull or open-drain output.
// - A pin in LED mode is open-drain: pulled low or released, never high.
// - Speed indicator goes low while the link runs at 100 megabit.
// - Speed indicator is high in negotiation, cable unplugged, or at 10 megabit.
// - Link and activity indicator stays low while a valid link exists.
// - Activity on a valid link turns that indicator high for 80 ms.
// - After each off pulse, low for at least 80 ms before another pulse.
// - Duplex indicator is low in full duplex on a valid link, released otherwise.
`timescale 1ns/1ps
`include "lsp_defines.vh"

module lsp_status_pins
#(
   parameter integer BLINK_CYCLES = `LSP_BLINK_CYCLES,
   parameter integer CNT_W        = 24,
   parameter integer PINS         = 3
)
(
   input  wire                   mclk,
   input  wire                   resetn,
   input  wire [`LSP_ADDR_W-1:0] regAddr,
   input  wire [31:0]            regWdata,
   input  wire                   regWrite,
   input  wire                   regRead,
   output reg  [31:0]            regRdata,
   input  wire                   phyLinkUp,
   input  wire                   phySpeed100,
   input  wire                   phyFullDuplex,
   input  wire                   phyAnegBusy,
   input  wire                   phyActivity,
   input  wire                   crossover_auto_strap,
   output reg                    crossoverAutoEn,
   input  wire [PINS-1:0]        gpioPinIn,
   output reg  [PINS-1:0]        gpioPinOut,
   output reg  [PINS-1:0]        gpioPinOe
);

   // ************************************************************
   // Constants and state
   // ************************************************************
   localparam [1:0]  BLINK_IDLE  = 2'h0;
   localparam [1:0]  BLINK_OFF   = 2'h1;
   localparam [1:0]  BLINK_MINON = 2'h2;
   localparam [31:0] BLINK_LAST32 = BLINK_CYCLES - 1;
   localparam [CNT_W-1:0] BLINK_LAST = BLINK_LAST32[CNT_W-1:0];

   reg  [PINS-1:0]  cfgDir;
   reg  [PINS-1:0]  cfgOpenDrain;
   reg  [PINS-1:0]  cfgLed;
   reg  [PINS-1:0]  dataOut;
   reg  [1:0]       strapWait;
   reg              strapTaken;
   reg  [1:0]       blinkState;
   reg  [1:0]       next_blinkState;
   reg  [CNT_W-1:0] blinkCount;
   reg  [CNT_W-1:0] next_blinkCount;
   reg  [PINS-1:0]  ledLow;
   reg  [PINS-1:0]  next_pinOut;
   reg  [PINS-1:0]  next_pinOe;
   reg  [31:0]      next_rdata;
   wire [PINS-1:0]  pinSync;
   wire             strapSync;
   wire             speed100Up;
   wire             intervalDone;

   // ************************************************************
   // Pin input synchronisers
   // ************************************************************
   // Pins and strap come from the board, so two flops first
   lsp_sync2 #(.WIDTH(PINS + 1)) uSync
   (
      .mclk    (mclk),
      .resetn  (resetn),
      .asyncIn ({crossover_auto_strap, gpioPinIn}),
      .syncOut ({strapSync, pinSync})
   );

   // ************************************************************
   // Crossover strap capture
   // ************************************************************
   // Wait for the synchroniser to fill, then take the strap once.
   // Reset value is enabled, matching a floating pin with pull-up.
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         strapWait       <= 2'h0;
         strapTaken      <= 1'b0;
         crossoverAutoEn <= `LSP_XOVER_RESET;
      end
      else if (!strapTaken)
      begin
         if (strapWait == `LSP_STRAP_SETTLE)
         begin
            crossoverAutoEn <= strapSync;
            strapTaken      <= 1'b1;
         end
         else
         begin
            strapWait <= strapWait + 2'h1;
         end
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Only the low bits of each field are kept; upper bits ignored
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cfgDir       <= {PINS{1'b0}};
         cfgOpenDrain <= {PINS{1'b0}};
         cfgLed       <= {PINS{1'b0}};
         dataOut      <= {PINS{1'b0}};
      end
      else if (regWrite)
      begin
         if (regAddr == `LSP_OFS_CFG)
         begin
            cfgDir       <= regWdata[`LSP_CFG_DIR_LSB +: PINS];
            cfgOpenDrain <= regWdata[`LSP_CFG_OD_LSB +: PINS];
            cfgLed       <= regWdata[`LSP_CFG_LED_LSB +: PINS];
         end
         else if (regAddr == `LSP_OFS_DATA)
         begin
            dataOut <= regWdata[`LSP_DATA_OUT_LSB +: PINS];
         end
      end
   end

   // ************************************************************
   // Activity blink timer
   // ************************************************************
   assign intervalDone = (blinkCount == BLINK_LAST);

   // Next state of the blink sequencer
   always @*
   begin
      next_blinkState = blinkState;
      next_blinkCount = blinkCount;
      case (blinkState)
         BLINK_IDLE:
         begin
            next_blinkCount = {CNT_W{1'b0}};
            if (phyLinkUp && phyActivity)
            begin
               next_blinkState = BLINK_OFF;
            end
         end
         BLINK_OFF:
         begin
            if (intervalDone)
            begin
               next_blinkState = BLINK_MINON;
               next_blinkCount = {CNT_W{1'b0}};
            end
            else
            begin
               next_blinkCount = blinkCount + 1'b1;
            end
         end
         BLINK_MINON:
         begin
            if (intervalDone)
            begin
               next_blinkState = BLINK_IDLE;
               next_blinkCount = {CNT_W{1'b0}};
            end
            else
            begin
               next_blinkCount = blinkCount + 1'b1;
            end
         end
         default:
         begin
            next_blinkState = BLINK_IDLE;
            next_blinkCount = {CNT_W{1'b0}};
         end
      endcase
      // Losing the link abandons any interval at once
      if (!phyLinkUp)
      begin
         next_blinkState = BLINK_IDLE;
         next_blinkCount = {CNT_W{1'b0}};
      end
   end

   // Blink sequencer registers
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         blinkState <= BLINK_IDLE;
         blinkCount <= {CNT_W{1'b0}};
      end
      else
      begin
         blinkState <= next_blinkState;
         blinkCount <= next_blinkCount;
      end
   end

   // ************************************************************
   // Indicator levels (1 means pull the pin low)
   // ************************************************************
   assign speed100Up = phyLinkUp && phySpeed100 && !phyAnegBusy;

   always @*
   begin
      ledLow[`LSP_PIN_SPEED] = speed100Up;
      ledLow[`LSP_PIN_LINKACT] = phyLinkUp && (blinkState != BLINK_OFF);
      ledLow[`LSP_PIN_DUPLEX] = phyLinkUp && phyFullDuplex;
   end

   // ************************************************************
   // Pin drivers
   // ************************************************************
   // LED mode overrides the general I/O settings of that pin
   always @*
   begin : pinDrive
      integer i;
      i           = 0;
      next_pinOut = {PINS{1'b0}};
      next_pinOe  = {PINS{1'b0}};
      for (i = 0; i < PINS; i = i + 1)
      begin
         if (cfgLed[i])
         begin
            next_pinOut[i] = 1'b0;
            next_pinOe[i]  = ledLow[i];
         end
         else if (cfgDir[i] && cfgOpenDrain[i])
         begin
            next_pinOut[i] = 1'b0;
            next_pinOe[i]  = !dataOut[i];
         end
         else if (cfgDir[i])
         begin
            next_pinOut[i] = dataOut[i];
            next_pinOe[i]  = 1'b1;
         end
      end
   end

   // Pin outputs leave straight from flops
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         gpioPinOut <= {PINS{1'b0}};
         gpioPinOe  <= {PINS{1'b0}};
      end
      else
      begin
         gpioPinOut <= next_pinOut;
         gpioPinOe  <= next_pinOe;
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   // Read data shows for one cycle only; idle and unmapped read zero
   always @*
   begin
      next_rdata = 32'h0000_0000;
      if (regRead)
      begin
         case (regAddr)
            `LSP_OFS_CFG:
            begin
               next_rdata[`LSP_CFG_DIR_LSB +: PINS] = cfgDir;
               next_rdata[`LSP_CFG_OD_LSB +: PINS]  = cfgOpenDrain;
               next_rdata[`LSP_CFG_LED_LSB +: PINS] = cfgLed;
            end
            `LSP_OFS_DATA:
            begin
               next_rdata[`LSP_DATA_OUT_LSB +: PINS] = dataOut;
               next_rdata[`LSP_DATA_IN_LSB +: PINS]  = pinSync;
            end
            `LSP_OFS_STATUS:
            begin
               next_rdata[`LSP_ST_XOVER]       = crossoverAutoEn;
               next_rdata[`LSP_ST_LINK]        = phyLinkUp;
               next_rdata[`LSP_ST_SPEED100]    = phySpeed100;
               next_rdata[`LSP_ST_FULLDUP]     = phyFullDuplex;
               next_rdata[`LSP_ST_ANEG]        = phyAnegBusy;
               next_rdata[`LSP_ST_BLINK_OFF]   = (blinkState == BLINK_OFF);
               next_rdata[`LSP_ST_BLINK_MINON] = (blinkState == BLINK_MINON);
            end
            default:
            begin
               next_rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // Read data register
   always @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         regRdata <= 32'h0000_0000;
      end
      else
      begin
         regRdata <= next_rdata;
      end
   end

endmodule

// ==== test/lsp_status_pins_props.sv ====
`timescale 1ns/1ps
`include "lsp_defines.vh"
// ****
// Port checker
// ****
module lsp_status_pins_props
#(
   parameter integer BLINK_CYCLES = `LSP_BLINK_CYCLES,
   parameter integer PINS         = 3
)
(
   input logic                   mclk,
   input logic                   resetn,
   input logic [`LSP_ADDR_W-1:0] regAddr,
   input logic [31:0]            regWdata,
   input logic                   regWrite,
   input logic                   regRead,
   input logic [31:0]            regRdata,
   input logic                   phyLinkUp,
   input logic                   phySpeed100,
   input logic                   phyFullDuplex,
   input logic                   phyAnegBusy,
   input logic                   crossoverAutoEn,
   input logic [PINS-1:0]        gpioPinOut,
   input logic [PINS-1:0]        gpioPinOe
);
   logic [10:0] cfg;
   logic [2:0]  dOut;
   logic [2:0]  sinceRst;
   logic [31:0] offCnt;
   logic        seenEdge = 1'b0;
   wire  [2:0]  led = cfg[10:8];
   wire  [2:0]  pp  = cfg[2:0] & ~cfg[6:4] & ~led;
   wire  [2:0]  od  = cfg[2:0] & cfg[6:4] & ~led;

   // Shadow of config and data; dark span counted only while link stays up
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         cfg      <= 11'h000;
         dOut     <= 3'h0;
         sinceRst <= 3'h0;
         offCnt   <= 32'h0;
      end
      else
      begin
         if (regWrite && regAddr == `LSP_OFS_CFG)
            cfg <= regWdata[10:0];
         if (regWrite && regAddr == `LSP_OFS_DATA)
            dOut <= regWdata[2:0];
         if (sinceRst != 3'h7)
            sinceRst <= sinceRst + 3'h1;
         offCnt <= (!gpioPinOe[1] && phyLinkUp && led[1]) ? offCnt + 32'h1 : 32'h0;
      end

   // First edge finds flops not yet reset, so reset checks skip it
   always @(posedge mclk)
      seenEdge <= 1'b1;

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   reset_pins_a: assert property (disable iff (1'b0)
      !resetn && seenEdge |-> gpioPinOe == 3'h0 && crossoverAutoEn)
      else $error("reset pin state");
   read_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
      else $error("read data outside slot");
   speed_lit_a: assert property (
      led[0] && phyLinkUp && phySpeed100 && !phyAnegBusy |=> gpioPinOe[0] && !gpioPinOut[0])
      else $error("speed led not lit");
   speed_dark_a: assert property (
      led[0] && !(phyLinkUp && phySpeed100 && !phyAnegBusy) |=> !gpioPinOe[0])
      else $error("speed led not dark");
   duplex_release_a: assert property (
      led[2] && !(phyLinkUp && phyFullDuplex) |=> !gpioPinOe[2] && !gpioPinOut[2])
      else $error("duplex led not released");
   link_dark_a: assert property (led[1] && !phyLinkUp |=> !gpioPinOe[1])
      else $error("link led lit without link");
   off_max_a: assert property (offCnt <= BLINK_CYCLES)
      else $error("dark span too long");
   off_full_a: assert property ($rose(gpioPinOe[1]) && offCnt > 32'h2
      |-> offCnt == BLINK_CYCLES) else $error("dark span wrong length");
   push_pull_a: assert property (|pp |=> (gpioPinOe & $past(pp)) == $past(pp)
      && (gpioPinOut & $past(pp)) == ($past(dOut) & $past(pp))) else $error("push-pull drive");
   open_drain_a: assert property (|od |=> (gpioPinOut & $past(od)) == 3'h0
      && (gpioPinOe & $past(od)) == (~$past(dOut) & $past(od))) else $error("open-drain drive");
   strap_hold_a: assert property (sinceRst == 3'h7 |-> $stable(crossoverAutoEn))
      else $error("crossover flag moved");
endmodule

bind lsp_status_pins lsp_status_pins_props #(.BLINK_CYCLES(BLINK_CYCLES), .PINS(PINS)) chk (
   .mclk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .phyLinkUp,
   .phySpeed100, .phyFullDuplex, .phyAnegBusy, .crossoverAutoEn, .gpioPinOut, .gpioPinOe);

// ==== test/lsp_pad_model.sv ====
`timescale 1ns/1ps
// ****
// Board pads
// ****
module lsp_pad_model
(
   input  logic [2:0] pinOut,
   input  logic [2:0] pinOe,
   input  logic [2:0] extOe,
   input  logic [2:0] extVal,
   input  logic       strapOe,
   input  logic       strapVal,
   output logic [2:0] padLevel,
   output logic       strapLevel
);
   // Pull-ups win when nobody drives; an LED only sinks
   assign padLevel   = pinOe & pinOut | ~pinOe & (~extOe | extVal);
   // Unfitted strap reads high
   assign strapLevel = strapOe ? strapVal : 1'b1;
endmodule

// ==== test/lsp_status_pins_bench.sv ====
`timescale 1ns/1ps
`include "lsp_defines.vh"
// ****
// Bench
// ****
module lsp_status_pins_bench;
   localparam integer BLINK = 8;
   logic                   mclk        = 1'b0;
   logic                   resetn      = 1'b0;
   logic [`LSP_ADDR_W-1:0] regAddr     = 8'h00;
   logic [31:0]            regWdata    = 32'h0;
   logic                   regWrite    = 1'b0;
   logic                   regRead     = 1'b0;
   logic [3:0]             phy         = 4'h0;
   logic                   phyActivity = 1'b0;
   logic [2:0]             extOe       = 3'h0;
   logic [2:0]             extVal      = 3'h0;
   logic                   strapOe     = 1'b1;
   logic                   strapVal    = 1'b0;
   logic [31:0]            regRdata;
   logic [2:0]             padLevel;
   logic [2:0]             gpioPinOut;
   logic [2:0]             gpioPinOe;
   logic                   strapLevel;
   logic                   crossoverAutoEn;
   integer                 err_count   = 0;
   integer                 checks_done = 0;
   integer                 n;
   integer                 c;
   // Rows: cfg[23:13] data[12:10] link,speed,duplex,aneg[9:6] oe[5:3] out[2:0]
   logic [23:0]            rows [0:9] = '{24'he00000, 24'he00210, 24'he00318, 24'he00350,
      24'he002b0, 24'he00180, 24'h00f43d, 24'h0ef7d0, 24'ha26ab2, 24'h001c00};

   lsp_status_pins #(.BLINK_CYCLES(BLINK)) uut (
      .mclk                 (mclk),
      .resetn               (resetn),
      .regAddr              (regAddr),
      .regWdata             (regWdata),
      .regWrite             (regWrite),
      .regRead              (regRead),
      .regRdata             (regRdata),
      .phyLinkUp            (phy[3]),
      .phySpeed100          (phy[2]),
      .phyFullDuplex        (phy[1]),
      .phyAnegBusy          (phy[0]),
      .phyActivity          (phyActivity),
      .crossover_auto_strap (strapLevel),
      .crossoverAutoEn      (crossoverAutoEn),
      .gpioPinIn            (padLevel),
      .gpioPinOut           (gpioPinOut),
      .gpioPinOe            (gpioPinOe));

   lsp_pad_model pads (.pinOut(gpioPinOut), .pinOe(gpioPinOe), .extOe(extOe), .extVal(extVal),
      .strapOe(strapOe), .strapVal(strapVal), .padLevel(padLevel), .strapLevel(strapLevel));

   // Free-running core clock
   always #2.5 mclk = ~mclk;

   task cyc(input integer k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRead <= 1'b0;
      #1;
      check(regRdata, exp);
   endtask

   // Edges spent at one level of the link LED, capped so it never hangs
   task span(input logic lvl);
      c = 0;
      while (gpioPinOe[1] === lvl && c < 40)
      begin
         @(posedge mclk);
         #1;
         c++;
      end
   endtask

   task wrap_up;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      cyc(7);
      check(32'(gpioPinOe), 32'h0);
      check(32'(crossoverAutoEn), 32'h1);
      @(posedge mclk);
      resetn <= 1'b1;
      cyc(8);
      check(32'(crossoverAutoEn), 32'h0);
      rd(`LSP_OFS_CFG, 32'h0);
      for (n = 0; n < 10; n++)
      begin
         wr(`LSP_OFS_CFG, {21'h0, rows[n][23:13]});
         wr(`LSP_OFS_DATA, {29'h0, rows[n][12:10]});
         phy <= rows[n][9:6];
         cyc(3);
         check(32'(gpioPinOe), 32'(rows[n][5:3]));
         check(32'(gpioPinOut), 32'(rows[n][2:0]));
         rd(`LSP_OFS_CFG, {21'h0, rows[n][23:13]});
      end
      // Unmapped place is ignored and reads zero
      wr(8'h0c, 32'hffffffff);
      rd(8'h0c, 32'h0);
      rd(`LSP_OFS_CFG, 32'h0);
      // Status and synchronised pad levels
      @(posedge mclk);
      phy    <= 4'he;
      extOe  <= 3'h7;
      extVal <= 3'h5;
      cyc(4);
      rd(`LSP_OFS_STATUS, 32'h0000000e);
      rd(`LSP_OFS_DATA, 32'h00000057);
      // Blink with activity held, then dropped
      wr(`LSP_OFS_CFG, 32'h00000200);
      phy <= 4'h8;
      cyc(3);
      check(32'(gpioPinOe), 32'h2);
      @(posedge mclk);
      phyActivity <= 1'b1;
      #1;
      span(1'b1);
      span(1'b0);
      check(32'(c), 32'(BLINK));
      span(1'b1);
      check(32'(c), 32'(BLINK + 1));
      span(1'b0);
      check(32'(c), 32'(BLINK));
      @(posedge mclk);
      phyActivity <= 1'b0;
      #1;
      rd(`LSP_OFS_STATUS, 32'h00000042);
      span(1'b1);
      check(32'(c), 32'd40);
      // Second reset with the strap left open
      @(posedge mclk);
      resetn  <= 1'b0;
      strapOe <= 1'b0;
      cyc(8);
      check(32'(gpioPinOe), 32'h0);
      @(posedge mclk);
      resetn <= 1'b1;
      cyc(8);
      check(32'(crossoverAutoEn), 32'h1);
      @(posedge mclk);
      strapOe <= 1'b1;
      cyc(8);
      check(32'(crossoverAutoEn), 32'h1);
      rd(`LSP_OFS_CFG, 32'h0);
      // Off interval shows in status with strap captured open
      @(posedge mclk);
      phyActivity <= 1'b1;
      rd(`LSP_OFS_STATUS, 32'h00000023);
      wrap_up;
   end
endmodule
